// ### src/nfcdc_map.svh
// Direct command codes and the decoder action count.
// Assumes inclusion by the decoder module and the bench only.
`ifndef NFCDC_MAP_SVH
`define NFCDC_MAP_SVH

`define NFCDC_CMD_CAL_DRV    8'hd8
`define NFCDC_CMD_MEAS_PHASE 8'hd9
`define NFCDC_CMD_CLR_RSSI   8'hda
`define NFCDC_CMD_CLR_FIFO   8'hdb
`define NFCDC_CMD_TRANSP     8'hdc
`define NFCDC_CMD_MEAS_SUPP  8'hdf
`define NFCDC_CMD_GPT_START  8'he0
`define NFCDC_CMD_WUT_START  8'he1
`define NFCDC_CMD_MRT_START  8'he2
`define NFCDC_CMD_NRT_START  8'he3
`define NFCDC_CMD_PPT_START  8'he4
`define NFCDC_CMD_NRT_STOP   8'he8

`define NFCDC_NUM_ACT        12

`endif

// ### src/nfcdc_pkg.sv
// Types shared by the direct command decoder.
// Assumes the constants header is on the include path.
package nfcdc_pkg;
  typedef enum logic [3:0] {
    NFCDC_A_CAL_DRV    = 4'h0,
    NFCDC_A_MEAS_PHASE = 4'h1,
    NFCDC_A_CLR_RSSI   = 4'h2,
    NFCDC_A_CLR_FIFO   = 4'h3,
    NFCDC_A_TRANSP     = 4'h4,
    NFCDC_A_MEAS_SUPP  = 4'h5,
    NFCDC_A_GPT_START  = 4'h6,
    NFCDC_A_WUT_START  = 4'h7,
    NFCDC_A_MRT_START  = 4'h8,
    NFCDC_A_NRT_START  = 4'h9,
    NFCDC_A_PPT_START  = 4'ha,
    NFCDC_A_NRT_STOP   = 4'hb
  } nfcdc_act_t;

  typedef enum logic [0:0] {
    NFCDC_S_IDLE = 1'b0,
    NFCDC_S_HOLD = 1'b1
  } nfcdc_state_t;
endpackage

// ### src/nfcdc_decoder.sv
// Direct command decoder: one host byte in, the matching action outputs out.
// Assumes cmd_valid/cmd_code come from the host interface logic on mclk.
//
// Functional notes
// - Code DA zeroes the signal strength bits and restarts the measurement.
// - Code DB empties the transmit/receive buffer and its fill level.
// - Code DC switches the device into transparent mode.
// - Code DF starts a supply voltage measurement.
// - Code D9 measures phase between antenna driver output and receiver input.
// - Code D8 starts a driver timing calibration with the current setting.
// - Code E0 starts the general purpose timer.
// - Code E1 starts the wake-up timer except while in the wake-up state.
// - Code E2 starts the receive-masking timer together with squelch.
// - Code E3 starts the no-response timer and E8 stops it.
// - Code E4 starts the secondary peer power-on timer.
// - The D8 calibration takes its setting from the driver timing display.
`timescale 1ns/1ns
`include "nfcdc_map.svh"

module nfcdc_decoder #(
  parameter int DRV_W = 4
) (
  input  wire logic             mclk,        // System clock, 50 MHz
  input  wire logic             rst_b,       // Async reset, active low
  input  wire logic             clk_en,      // Clock enable, freezes state
  input  wire logic             cmd_valid,   // One-cycle pulse: byte present
  input  wire logic [7:0]       cmd_code,    // Command byte
  input  wire logic             wake_up_state, // Device is in wake-up state
  input  wire logic [DRV_W-1:0] drv_timing,  // Driver timing display value
  output logic                  rssi_clear,  // Pulse: clear strength bits
  output logic                  rssi_start,  // Pulse: restart strength meas
  output logic                  fifo_clear,  // Pulse: empty buffer
  output logic                  transparent, // Level: transparent mode
  output logic                  meas_supply, // Pulse: supply measurement
  output logic                  meas_phase,  // Pulse: phase measurement
  output logic                  cal_start,   // Pulse: calibration start
  output logic [DRV_W-1:0]      cal_setting, // Setting captured for cal
  output logic                  gpt_start,   // Pulse: general timer start
  output logic                  wut_start,   // Pulse: wake-up timer start
  output logic                  mrt_start,   // Pulse: mask-receive start
  output logic                  squelch_start, // Pulse: squelch start
  output logic                  nrt_start,   // Pulse: no-response start
  output logic                  nrt_stop,    // Pulse: no-response stop
  output logic                  ppt_start,   // Pulse: peer power-on start
  output logic                  cmd_ignored  // Pulse: code undefined/refused
);
  import nfcdc_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  localparam logic [7:0] CODES [`NFCDC_NUM_ACT] = '{
    `NFCDC_CMD_CAL_DRV, `NFCDC_CMD_MEAS_PHASE, `NFCDC_CMD_CLR_RSSI,
    `NFCDC_CMD_CLR_FIFO, `NFCDC_CMD_TRANSP, `NFCDC_CMD_MEAS_SUPP,
    `NFCDC_CMD_GPT_START, `NFCDC_CMD_WUT_START, `NFCDC_CMD_MRT_START,
    `NFCDC_CMD_NRT_START, `NFCDC_CMD_PPT_START, `NFCDC_CMD_NRT_STOP};

  wire logic [`NFCDC_NUM_ACT-1:0] hit;
  wire logic [`NFCDC_NUM_ACT-1:0] act;
  wire logic                      take;
  wire logic                      wut_block;

  // A byte is taken in each cycle its strobe is seen with clk_en high
  assign take = cmd_valid & clk_en;

  genvar gi;
  generate
    for (gi = 0; gi < `NFCDC_NUM_ACT; gi++) begin : g_dec
      assign hit[gi] = take & (cmd_code == CODES[gi]);
    end
  endgenerate

  // Wake-up timer cannot be restarted from inside the wake-up state
  assign wut_block = hit[NFCDC_A_WUT_START] & wake_up_state;
  assign act = hit & ~({{(`NFCDC_NUM_ACT-1){1'b0}}, wut_block}
                       << NFCDC_A_WUT_START);

  // ---------------------------------------------------------------
  // Action pulses
  // ---------------------------------------------------------------
  nfcdc_state_t state;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rssi_clear    <= 1'b0;
      rssi_start    <= 1'b0;
      fifo_clear    <= 1'b0;
      meas_supply   <= 1'b0;
      meas_phase    <= 1'b0;
      cal_start     <= 1'b0;
      gpt_start     <= 1'b0;
      wut_start     <= 1'b0;
      mrt_start     <= 1'b0;
      squelch_start <= 1'b0;
      nrt_start     <= 1'b0;
      nrt_stop      <= 1'b0;
      ppt_start     <= 1'b0;
      cmd_ignored   <= 1'b0;
    end else if (clk_en) begin
      rssi_clear    <= act[NFCDC_A_CLR_RSSI];
      rssi_start    <= act[NFCDC_A_CLR_RSSI];
      fifo_clear    <= act[NFCDC_A_CLR_FIFO];
      meas_supply   <= act[NFCDC_A_MEAS_SUPP];
      meas_phase    <= act[NFCDC_A_MEAS_PHASE];
      cal_start     <= act[NFCDC_A_CAL_DRV];
      gpt_start     <= act[NFCDC_A_GPT_START];
      wut_start     <= act[NFCDC_A_WUT_START];
      mrt_start     <= act[NFCDC_A_MRT_START];
      squelch_start <= act[NFCDC_A_MRT_START];
      nrt_start     <= act[NFCDC_A_NRT_START];
      nrt_stop      <= act[NFCDC_A_NRT_STOP];
      ppt_start     <= act[NFCDC_A_PPT_START];
      cmd_ignored   <= take & ~(|act);
    end
  end

  // Setting is latched with the start so later display changes can't
  // disturb a calibration already under way
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cal_setting <= '0;
    end else if (clk_en && act[NFCDC_A_CAL_DRV]) begin
      cal_setting <= drv_timing;
    end
  end

  // ---------------------------------------------------------------
  // Transparent mode
  // ---------------------------------------------------------------
  // Held until reset; leaving the mode is outside this decoder
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= NFCDC_S_IDLE;
    end else if (clk_en) begin
      case (state)
        NFCDC_S_IDLE: begin
          if (act[NFCDC_A_TRANSP]) state <= NFCDC_S_HOLD;
        end
        NFCDC_S_HOLD: state <= NFCDC_S_HOLD;
        default:      state <= NFCDC_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) transparent <= 1'b0;
    else if (clk_en) transparent <= (state == NFCDC_S_HOLD) |
                                    act[NFCDC_A_TRANSP];
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_rssi_restart: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hda) |=> (rssi_clear && rssi_start))
    else $error("clear strength did not restart measurement");
  a_fifo_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hdb) |=> fifo_clear)
    else $error("buffer clear missing");
  a_transp_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hdc) |=> transparent [*3])
    else $error("transparent mode not held");
  a_supply_meas: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(meas_supply) |-> $past(cmd_code) == 8'hdf)
    else $error("supply measurement from wrong code");
  a_phase_meas: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hd9) |=> meas_phase)
    else $error("phase measurement missing");
  a_cal_setting: assert property (@(posedge mclk) disable iff (!rst_b)
    cal_start |-> cal_setting == $past(drv_timing))
    else $error("calibration setting not captured");
  a_wut_blocked: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he1 && wake_up_state) |=>
    !wut_start && cmd_ignored)
    else $error("wake-up timer started in wake-up state");
  a_mask_squelch: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he2) |=>
    (mrt_start && squelch_start))
    else $error("mask timer and squelch out of step");
  a_nrt_excl: assert property (@(posedge mclk) disable iff (!rst_b)
    !(nrt_start && nrt_stop))
    else $error("no-response start and stop together");
  a_gpt_ppt: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he0) |=> gpt_start && !ppt_start)
    else $error("general timer start wrong");
  a_ppt_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he4) |=> ppt_start)
    else $error("peer power-on timer start missing");
  a_once_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !cmd_valid) |=> !(fifo_clear || gpt_start || cmd_ignored))
    else $error("action without a command");
  a_cal_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hd8) |=> cal_start)
    else $error("calibration start missing");
  a_nrt_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he3) |=> (nrt_start && !nrt_stop))
    else $error("no-response start missing");
  a_nrt_stop: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he8) |=> (nrt_stop && !nrt_start))
    else $error("no-response stop missing");
  a_wut_start: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'he1 && !wake_up_state) |=>
    (wut_start && !cmd_ignored))
    else $error("wake-up timer start missing");
  a_supply_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && cmd_code == 8'hdf) |=> meas_supply)
    else $error("supply measurement missing");
  // Undefined codes must raise cmd_ignored and leave fifo_clear and gpt_start quiet
  a_undef_code: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && cmd_valid && !(cmd_code inside {8'hd8, 8'hd9, 8'hda, 8'hdb,
    8'hdc, 8'hdf, 8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he8})) |=>
    (cmd_ignored && !fifo_clear && !gpt_start))
    else $error("undefined code not ignored");
  a_cal_stable: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !(cmd_valid && cmd_code == 8'hd8)) |=> $stable(cal_setting))
    else $error("calibration setting changed without a command");
  a_rssi_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !(cmd_valid && cmd_code == 8'hda)) |=>
    (!rssi_clear && !rssi_start))
    else $error("strength clear without its command");
  a_fifo_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !(cmd_valid && cmd_code == 8'hdb)) |=> !fifo_clear)
    else $error("buffer clear without its command");
  a_phase_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !(cmd_valid && cmd_code == 8'hd9)) |=> !meas_phase)
    else $error("phase measurement without its command");
  a_transp_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    transparent |=> transparent)
    else $error("transparent mode dropped");
  a_ppt_only: assert property (@(posedge mclk) disable iff (!rst_b)
    (clk_en && !(cmd_valid && cmd_code == 8'he4)) |=> !ppt_start)
    else $error("peer power-on start without its command");
endmodule // nfcdc_decoder

// ### tb/nfcdc_host_model.sv
// Host model: issues one-byte direct commands to the decoder.
// Assumes the bench calls its tasks; it drives at the falling edge.
`timescale 1ns/1ns

module nfcdc_host_model (
  input  wire logic       mclk,      // System clock
  output logic            cmd_valid, // Command strobe
  output logic [7:0]      cmd_code   // Command byte
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
  end

  // One whole byte per command, held across one taking edge
  task automatic send(input logic [7:0] code);
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_code  = code;
  endtask

  // Idle byte lines carry junk so a stale code can never look valid
  task automatic idle();
    @(negedge mclk);
    cmd_valid = 1'b0;
    cmd_code  = ~cmd_code;
  endtask
endmodule // nfcdc_host_model

// ### tb/test_nfc_reader_direct_command_decoder.sv
// Bench for the direct command decoder, with a host model in front.
// Assumes the decoder answers one cycle after the taking edge.
`timescale 1ns/1ns
`include "nfcdc_map.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin \
  mismatches++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end

module test_nfc_reader_direct_command_decoder;
  logic mclk, rst_b, clk_en, cmd_valid, wake_up_state, transparent;
  logic [7:0] cmd_code;
  logic [3:0] drv_timing, cal_setting;
  logic rssi_clear, rssi_start, fifo_clear, meas_supply, meas_phase;
  logic cal_start, gpt_start, wut_start, mrt_start, squelch_start;
  logic nrt_start, nrt_stop, ppt_start, cmd_ignored;
  logic [13:0] pulses;
  int mismatches, check_count, cycles;

  assign pulses = {rssi_clear, rssi_start, fifo_clear, meas_supply,
    meas_phase, cal_start, gpt_start, wut_start, mrt_start, squelch_start,
    nrt_start, nrt_stop, ppt_start, cmd_ignored};

  nfcdc_host_model nfcdc_host_model_inst (.mclk(mclk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code));

  nfcdc_decoder nfcdc_decoder_inst (.mclk(mclk), .rst_b(rst_b),
    .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wake_up_state(wake_up_state), .drv_timing(drv_timing),
    .rssi_clear(rssi_clear), .rssi_start(rssi_start),
    .fifo_clear(fifo_clear), .transparent(transparent),
    .meas_supply(meas_supply), .meas_phase(meas_phase),
    .cal_start(cal_start), .cal_setting(cal_setting),
    .gpt_start(gpt_start), .wut_start(wut_start), .mrt_start(mrt_start),
    .squelch_start(squelch_start), .nrt_start(nrt_start),
    .nrt_stop(nrt_stop), .ppt_start(ppt_start), .cmd_ignored(cmd_ignored));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Whole run needs some 63 cycles; a hang stops well past that
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic one(input logic [7:0] code, input logic [13:0] ex);
    nfcdc_host_model_inst.send(code);
    nfcdc_host_model_inst.idle();
    `CHK("pulses", ex, pulses)
    @(negedge mclk);
    `CHK("pulses after", 14'h0000, pulses)
  endtask

  task automatic t_decode();
    one(`NFCDC_CMD_CLR_RSSI, 14'h3000);
    one(`NFCDC_CMD_CLR_FIFO, 14'h0800);
    one(`NFCDC_CMD_MEAS_SUPP, 14'h0400);
    one(`NFCDC_CMD_MEAS_PHASE, 14'h0200);
    one(`NFCDC_CMD_GPT_START, 14'h0080);
    one(`NFCDC_CMD_WUT_START, 14'h0040);
    one(`NFCDC_CMD_MRT_START, 14'h0030);
    one(`NFCDC_CMD_NRT_START, 14'h0008);
    one(`NFCDC_CMD_NRT_STOP, 14'h0004);
    one(`NFCDC_CMD_PPT_START, 14'h0002);
    one(8'he5, 14'h0001);
    wake_up_state = 1'b1;
    one(`NFCDC_CMD_WUT_START, 14'h0001);
    wake_up_state = 1'b0;
    $display("test decode done");
  endtask

  task automatic t_back_to_back();
    drv_timing = 4'ha;
    nfcdc_host_model_inst.send(`NFCDC_CMD_CAL_DRV);
    nfcdc_host_model_inst.send(`NFCDC_CMD_CAL_DRV);
    drv_timing = 4'h5;
    `CHK("cal first", 4'ha, cal_setting)
    `CHK("cal pulse", 14'h0100, pulses)
    nfcdc_host_model_inst.send(`NFCDC_CMD_NRT_START);
    `CHK("cal second", 4'h5, cal_setting)
    nfcdc_host_model_inst.idle();
    `CHK("nrt pulse", 14'h0008, pulses)
    $display("test back to back done");
  endtask

  task automatic t_frozen_transp();
    // Let the last pulse drain first, or the freeze would hold it high
    @(negedge mclk);
    clk_en = 1'b0;
    one(`NFCDC_CMD_CLR_FIFO, 14'h0000);
    clk_en = 1'b1;
    `CHK("transparent idle", 1'b0, transparent)
    one(`NFCDC_CMD_TRANSP, 14'h0000);
    one(`NFCDC_CMD_CLR_RSSI, 14'h3000);
    `CHK("transparent held", 1'b1, transparent)
    $display("test freeze and transparent done");
  endtask

  task automatic t_reset_mid();
    @(negedge mclk);
    rst_b = 1'b0;
    @(negedge mclk);
    `CHK("reset transparent", 1'b0, transparent)
    `CHK("reset cal", 4'h0, cal_setting)
    `CHK("reset pulses mid", 14'h0000, pulses)
    rst_b = 1'b1;
    one(`NFCDC_CMD_NRT_STOP, 14'h0004);
    `CHK("transparent after reset", 1'b0, transparent)
    $display("test mid-run reset done");
  endtask

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    wake_up_state = 1'b0;
    drv_timing = 4'h0;
    repeat (8) @(negedge mclk);
    `CHK("reset pulses", 14'h0000, pulses)
    rst_b = 1'b1;
    t_decode();
    t_back_to_back();
    t_frozen_transp();
    t_reset_mid();
    close_out();
  end
endmodule // test_nfc_reader_direct_command_decoder
